// [verilog/sas_params.svh]
// Purpose: constants for the sealing alarm supervisor
// Assumes: 25 MHz system clock
// Notes: offsets are byte addresses on the AXI4-Lite register bus
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define SAS_OFS_CTRL 8'h00
`define SAS_OFS_HEATLIM 8'h04
`define SAS_OFS_RESTART 8'h08
`define SAS_OFS_PAUSE 8'h0C
`define SAS_OFS_STATUS 8'h10
`define SAS_OFS_IRQ 8'h14
`define SAS_OFS_MASK 8'h18
`define SAS_OFS_ERR 8'h1C
// ----------------------------------------
// control fields
// ----------------------------------------
`define SAS_CTRL_HEATCHK 0
`define SAS_CTRL_TEMPCHK 1
`define SAS_CTRL_RELINV 2
`define SAS_CTRL_FAULT 3
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define SAS_CLK_HZ 25000000
`define SAS_RESTART_MS 200
`define SAS_RESTART_CYC ((`SAS_CLK_HZ / 1000) * `SAS_RESTART_MS)
`define SAS_PAUSE_PERIODS 8'h0A
`define SAS_HEATLIM_RST 32'h017D_7840
`define SAS_BLINK4_HZ 4
`define SAS_BLINK4_HALF (`SAS_CLK_HZ / (2 * `SAS_BLINK4_HZ))
`define SAS_ERR_HEATUP 12'h130
`define SAS_ERR_TEMPLOW 12'h133
`define SAS_ERR_TEMPHIGH 12'h134
`define SAS_DAC_FULL 12'hFFF
`define SAS_DAC_ZERO 12'h000
`endif

// [verilog/sas_pkg.sv]
// Purpose: types for the sealing alarm supervisor
// Assumes: nothing
// Notes: error class drives led, relay and analogue coding
package sas_pkg;
  typedef enum logic [3:0] {
    SAS_NONE = 4'b0001,
    SAS_CAL = 4'b0010,
    SAS_CFG = 4'b0100,
    SAS_FAULT = 4'b1000
  } sas_class_t;
  typedef enum logic [2:0] {
    SAS_RUN = 3'b001,
    SAS_HOLD = 3'b010,
    SAS_STBY = 3'b100
  } sas_state_t;
  typedef struct packed {
    logic [11:0] code;
    logic [3:0] level;
  } sas_err_t;
endpackage

// [verilog/sas_supervisor.sv]
// Purpose: alarm supervision of an impulse sealing controller
// Assumes: start, resetIn, supplyLow, termLost arrive from pins
// Notes: temperatures are unsigned codes from the measuring path
// Summary of operation
// - heat-up check runs only when enabled
// - timer starts on start, stops at 95 percent
// - timer overrun logs 304 and alarms
// - no measuring pulses during restart delay
// - measuring pause capped in mains periods
// - terminal loss raises nothing
// - supply low enters standby, pulses stopped
// - standby outputs zero volts, relay off
// - supply back resumes without reset
// - calibration errors blink led 4 Hz
// - configuration errors blink led 1 Hz
// - faults or start light led steadily
// - relay off when blinking unless start
// - polarity setting inverts relay
// - alarm shows error level on output
// - blinking classes alternate with full scale
// - error cleared on reset falling edge
// - leaving tolerance band logs 307/308
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "sas_params.svh"
module sas_supervisor #(
  parameter int RESTART_CYC = `SAS_RESTART_CYC,
  parameter int BLINK_HALF = `SAS_BLINK4_HALF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic startIn,
  input wire logic resetIn,
  input wire logic supplyLow,
  input wire logic termLost,
  input wire logic mainsTick,
  input wire logic overSet,
  input wire logic powerLow,
  input wire logic [11:0] actTemp,
  input wire logic [11:0] setTemp,
  input wire logic [11:0] bandLow,
  input wire logic [11:0] bandHigh,
  input wire logic extErrValid,
  input wire sas_pkg::sas_err_t extErr,
  input wire logic [3:0] extClass,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic measEn,
  output logic sealEn,
  output logic alarmLed,
  output logic alarmRelay,
  output logic [11:0] actOut,
  output logic irq
);
  // ----------------------------------------
  // reset and pin synchronisers
  // ----------------------------------------
  logic [1:0] rstSync_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rstSync_reg <= 2'b00;
    else rstSync_reg <= {rstSync_reg[0], 1'b1};
  end
  assign rst_n = rstSync_reg[1];

  logic [3:0] pinA_reg, pinB_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinA_reg <= 4'h0;
      pinB_reg <= 4'h0;
    end else begin
      pinA_reg <= {termLost, supplyLow, resetIn, startIn};
      pinB_reg <= pinA_reg;
    end
  end
  logic startS, resetS, lowS, resetOld_reg;
  assign startS = pinB_reg[0];
  assign resetS = pinB_reg[1];
  assign lowS = pinB_reg[2];
  // terminal loss (pinB_reg[3]) deliberately feeds no error or relay path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) resetOld_reg <= 1'b0;
    else resetOld_reg <= resetS;
  end
  logic resetFall, startOld_reg, startRise;
  assign resetFall = resetOld_reg & ~resetS;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) startOld_reg <= 1'b0;
    else startOld_reg <= startS;
  end
  assign startRise = startS & ~startOld_reg;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [3:0] ctrl_reg;
  logic [31:0] heatLim_reg, restart_reg;
  logic [7:0] pauseMax_reg;
  logic [2:0] irqStat_reg, irqMask_reg;
  sas_pkg::sas_err_t err_reg;
  sas_pkg::sas_class_t cls_reg;
  sas_pkg::sas_state_t st_reg;

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic awHave_reg, wHave_reg;
  logic [7:0] awA_reg;
  logic [31:0] wD_reg;
  logic [3:0] wS_reg;
  logic wrDo;
  assign wrDo = awHave_reg & wHave_reg & ~bvalid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      awA_reg <= 8'h00;
      wD_reg <= 32'h0000_0000;
      wS_reg <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'b00;
    end else begin
      if (awvalid && awready) begin
        awHave_reg <= 1'b1;
        awA_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_reg <= 1'b1;
        wD_reg <= wdata;
        wS_reg <= wstrb;
      end
      if (wrDo) begin
        awHave_reg <= 1'b0;
        wHave_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (awA_reg > `SAS_OFS_ERR || awA_reg[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      awready <= ~awHave_reg & ~(awvalid & awready);
      wready <= ~wHave_reg & ~(wvalid & wready);
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  logic [31:0] wrVal;
  assign wrVal = merge(32'h0000_0000, wD_reg, wS_reg);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= 4'h0;
      heatLim_reg <= `SAS_HEATLIM_RST;
      restart_reg <= RESTART_CYC;
      pauseMax_reg <= `SAS_PAUSE_PERIODS;
      irqMask_reg <= 3'h0;
    end else if (wrDo) begin
      unique case (awA_reg)
        `SAS_OFS_CTRL: ctrl_reg <= wS_reg[0] ? wD_reg[3:0] : ctrl_reg;
        `SAS_OFS_HEATLIM: heatLim_reg <= merge(heatLim_reg, wD_reg, wS_reg);
        `SAS_OFS_RESTART: restart_reg <= merge(restart_reg, wD_reg, wS_reg);
        `SAS_OFS_PAUSE: pauseMax_reg <= wS_reg[0] ? wD_reg[7:0] : pauseMax_reg;
        `SAS_OFS_MASK: irqMask_reg <= wS_reg[0] ? wD_reg[2:0] : irqMask_reg;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
    end else begin
      arready <= ~rvalid & ~(arvalid & arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= 2'b00;
        unique case (araddr)
          `SAS_OFS_CTRL: rdata <= {28'h0, ctrl_reg};
          `SAS_OFS_HEATLIM: rdata <= heatLim_reg;
          `SAS_OFS_RESTART: rdata <= restart_reg;
          `SAS_OFS_PAUSE: rdata <= {24'h0, pauseMax_reg};
          `SAS_OFS_STATUS: rdata <= {25'h0, st_reg, cls_reg};
          `SAS_OFS_IRQ: rdata <= {29'h0, irqStat_reg};
          `SAS_OFS_MASK: rdata <= {29'h0, irqMask_reg};
          `SAS_OFS_ERR: rdata <= {16'h0, err_reg};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= 2'b10;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // heat-up and tolerance checks
  // ----------------------------------------
  logic [31:0] heatCnt_reg;
  logic heatRun_reg, inBand_reg, heatErr, bandErr, bandOk;
  logic [13:0] thr95;
  // 95 percent of setpoint, integer approximation: set*95/100
  assign thr95 = 14'((19'(setTemp) * 19'd95) / 19'd100);
  assign bandOk = (actTemp >= bandLow) && (actTemp <= bandHigh);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      heatRun_reg <= 1'b0;
      heatCnt_reg <= 32'h0000_0000;
    end else if (!ctrl_reg[`SAS_CTRL_HEATCHK] || !startS) begin
      heatRun_reg <= 1'b0;
      heatCnt_reg <= 32'h0000_0000;
    end else if (startRise) begin
      heatRun_reg <= 1'b1;
      heatCnt_reg <= 32'h0000_0000;
    end else if (heatRun_reg) begin
      if (14'(actTemp) >= thr95) heatRun_reg <= 1'b0;
      else heatCnt_reg <= heatCnt_reg + 32'h0000_0001;
    end
  end
  assign heatErr = heatRun_reg && (heatCnt_reg >= heatLim_reg);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) inBand_reg <= 1'b0;
    else if (!startS || !ctrl_reg[`SAS_CTRL_TEMPCHK]) inBand_reg <= 1'b0;
    else if (bandOk) inBand_reg <= 1'b1;
  end
  assign bandErr = inBand_reg && !bandOk;

  // ----------------------------------------
  // error latch, reset on falling edge only
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_reg <= '0;
      cls_reg <= sas_pkg::SAS_NONE;
    end else if (st_reg != sas_pkg::SAS_STBY && (heatErr || bandErr)) begin
      err_reg.code <= heatErr ? `SAS_ERR_HEATUP :
                      ((actTemp < bandLow) ? `SAS_ERR_TEMPLOW : `SAS_ERR_TEMPHIGH);
      err_reg.level <= heatErr ? 4'h6 : 4'h4;
      cls_reg <= sas_pkg::SAS_FAULT;
    end else if (extErrValid) begin
      err_reg <= extErr;
      cls_reg <= sas_pkg::sas_class_t'(extClass);
    end else if (resetFall) begin
      err_reg <= '0;
      cls_reg <= sas_pkg::SAS_NONE;
    end
  end
  logic alarm;
  assign alarm = cls_reg != sas_pkg::SAS_NONE;

  // ----------------------------------------
  // standby, restart delay, measuring pause
  // ----------------------------------------
  logic [31:0] rdCnt_reg;
  logic [7:0] pauseCnt_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= sas_pkg::SAS_RUN;
      rdCnt_reg <= 32'h0000_0000;
    end else if (lowS) begin
      st_reg <= sas_pkg::SAS_STBY;
    end else begin
      unique case (st_reg)
        sas_pkg::SAS_STBY: st_reg <= sas_pkg::SAS_RUN;
        sas_pkg::SAS_RUN: if (resetFall && alarm) begin
          st_reg <= sas_pkg::SAS_HOLD;
          rdCnt_reg <= restart_reg;
        end
        sas_pkg::SAS_HOLD: if (rdCnt_reg <= 32'h0000_0001) st_reg <= sas_pkg::SAS_RUN;
          else rdCnt_reg <= rdCnt_reg - 32'h0000_0001;
        default: st_reg <= sas_pkg::SAS_RUN;
      endcase
    end
  end
  logic pausing;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pauseCnt_reg <= 8'h00;
    else if (!(startS && overSet && powerLow)) pauseCnt_reg <= 8'h00;
    else if (mainsTick && pauseCnt_reg < pauseMax_reg) pauseCnt_reg <= pauseCnt_reg + 8'h01;
  end
  assign pausing = startS && overSet && powerLow && (pauseCnt_reg < pauseMax_reg);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      measEn <= 1'b0;
      sealEn <= 1'b0;
    end else begin
      measEn <= (st_reg == sas_pkg::SAS_RUN) && !lowS && !pausing;
      sealEn <= (st_reg == sas_pkg::SAS_RUN) && !lowS && startS && !alarm;
    end
  end

  // ----------------------------------------
  // blink timebase and indicators
  // ----------------------------------------
  logic [31:0] div_reg;
  logic [2:0] ph_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 32'h0000_0000;
      ph_reg <= 3'h0;
    end else if (div_reg >= 32'(BLINK_HALF - 1)) begin
      div_reg <= 32'h0000_0000;
      ph_reg <= ph_reg + 3'h1;
    end else begin
      div_reg <= div_reg + 32'h0000_0001;
    end
  end
  logic fast, slow, relayRaw, stby;
  assign fast = ph_reg[0];
  assign slow = ph_reg[2];
  assign stby = st_reg == sas_pkg::SAS_STBY;
  always_comb begin
    unique case (cls_reg)
      sas_pkg::SAS_CAL: relayRaw = startS;
      sas_pkg::SAS_CFG: relayRaw = startS;
      sas_pkg::SAS_FAULT: relayRaw = 1'b1;
      default: relayRaw = 1'b0;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmLed <= 1'b0;
      alarmRelay <= 1'b0;
      actOut <= `SAS_DAC_ZERO;
    end else begin
      unique case (cls_reg)
        sas_pkg::SAS_CAL: alarmLed <= startS | fast;
        sas_pkg::SAS_CFG: alarmLed <= startS | slow;
        sas_pkg::SAS_FAULT: alarmLed <= 1'b1;
        default: alarmLed <= 1'b0;
      endcase
      // standby forces the relay output low regardless of polarity
      alarmRelay <= stby ? 1'b0 : relayRaw ^ ctrl_reg[`SAS_CTRL_RELINV];
      if (stby) actOut <= `SAS_DAC_ZERO;
      else if (!alarm) actOut <= actTemp;
      else if (cls_reg != sas_pkg::SAS_FAULT && !startS && slow) actOut <= `SAS_DAC_FULL;
      else actOut <= {err_reg.level, 8'h00};
    end
  end

  // ----------------------------------------
  // interrupts: alarm, standby, band error
  // ----------------------------------------
  logic [2:0] ev, clr;
  assign ev = {bandErr, stby, heatErr | extErrValid};
  assign clr = (wrDo && awA_reg == `SAS_OFS_IRQ) ? wrVal[2:0] : 3'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_reg <= 3'h0;
      irq <= 1'b0;
    end else begin
      irqStat_reg <= (irqStat_reg & ~clr) | ev;
      irq <= |(((irqStat_reg & ~clr) | ev) & irqMask_reg);
    end
  end
endmodule // sas_supervisor

// [verification/sas_checker.sv]
// Purpose: port-level assertions for sas_supervisor
// Assumes: relay rules on blinking classes run with default polarity
// Notes: limits sized for the short simulation counts
`timescale 1ns/1ps
module sas_checker #(
  parameter int RESTART_CYC = 50,
  parameter int BLINK_HALF = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic startIn,
  input wire logic resetIn,
  input wire logic supplyLow,
  input wire logic mainsTick,
  input wire logic extErrValid,
  input wire sas_pkg::sas_err_t extErr,
  input wire logic [3:0] extClass,
  input wire logic measEn,
  input wire logic sealEn,
  input wire logic alarmLed,
  input wire logic alarmRelay,
  input wire logic [11:0] actOut
);
  localparam int RLO = RESTART_CYC - 20;
  localparam int RHI = RESTART_CYC + 30;
  logic [7:0] pauseCnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // helper: mains periods spent without measuring
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) pauseCnt <= 8'h00;
    else if (measEn) pauseCnt <= 8'h00;
    else if (mainsTick) pauseCnt <= pauseCnt + 8'h01;
  end
  // ----------------------------------------
  // sequences and assertions
  // ----------------------------------------
  sequence sAck;
    alarmRelay && $fell(resetIn);
  endsequence
  sequence sHold;
    !measEn [*8];
  endsequence
  sequence sCalHit;
    extErrValid && extClass == 4'b0010 && !startIn;
  endsequence
  a_restart_hold: assert property (sAck |-> ##[3:8] sHold ##[RLO:RHI] measEn)
    else $error("measuring not held then resumed after acknowledge");
  a_pause_cap: assert property (pauseCnt <= 8'h0B)
    else $error("measuring pause too long");
  a_standby_off: assert property (supplyLow [*6] |-> !measEn && !sealEn && actOut == 12'h000)
    else $error("pulses or output active in standby");
  a_standby_relay: assert property (supplyLow [*6] |-> !alarmRelay)
    else $error("relay active in standby");
  a_fault_steady: assert property (extErrValid && extClass == 4'b1000 |->
    ##[1:5] (alarmLed && actOut == {extErr.level, 8'h00}) [*4])
    else $error("fault not shown steadily");
  a_cal_blink: assert property (sCalHit |-> ##[1:12] $rose(alarmLed) ##[2:6] $fell(alarmLed))
    else $error("calibration blink missing");
  a_cal_relay: assert property (sCalHit |-> ##[2:5] !alarmRelay [*8])
    else $error("relay active while blinking");
  a_hold_high: assert property (resetIn [*6] ##1 (resetIn && $stable(startIn)) |->
    $stable(alarmRelay))
    else $error("alarm changed while reset held");
  a_clear_fall: assert property ($fell(resetIn) |-> ##[2:8] !alarmLed)
    else $error("alarm not cleared after reset release");
endmodule // sas_checker

bind sas_supervisor sas_checker #(.RESTART_CYC(RESTART_CYC), .BLINK_HALF(BLINK_HALF)) u_chk (
  .clk(clk), .rstn(rstn), .startIn(startIn), .resetIn(resetIn), .supplyLow(supplyLow),
  .mainsTick(mainsTick), .extErrValid(extErrValid), .extErr(extErr), .extClass(extClass),
  .measEn(measEn), .sealEn(sealEn), .alarmLed(alarmLed), .alarmRelay(alarmRelay),
  .actOut(actOut));

// [verification/sas_machine_ctl.sv]
// Purpose: machine controller model driving start and reset
// Assumes: requests arrive from the bench on clk
// Notes: reset is always a finite pulse, never a level
`timescale 1ns/1ps
module sas_machine_ctl (
  input wire logic clk,
  input wire logic runReq,
  input wire logic ackReq,
  input wire logic [7:0] ackLen,
  output logic startIn,
  output logic resetIn
);
  logic [7:0] ackCnt = 8'h00;
  logic startReg = 1'b0;
  always @(posedge clk) startReg <= runReq;
  always @(posedge clk) begin
    if (ackReq) ackCnt <= ackLen;
    else if (ackCnt != 8'h00) ackCnt <= ackCnt - 8'h01;
  end
  assign startIn = startReg;
  assign resetIn = (ackCnt != 8'h00);
endmodule // sas_machine_ctl

// [verification/tb_top.sv]
// Purpose: self-checking bench for sas_supervisor
// Assumes: RESTART_CYC 50 and BLINK_HALF 4 keep runs short
// Notes: a set mask bit enables its interrupt
`timescale 1ns/1ps
`include "sas_params.svh"
module tb_top;
  localparam int RST = 50;
  logic clk, rstn = 1'b0, supplyLow = 1'b0, termLost = 1'b0, mainsTick = 1'b0;
  logic overSet = 1'b0, powerLow = 1'b0, extErrValid = 1'b0, runReq = 1'b0, ackReq = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic startIn, resetIn, awready, wready, bvalid, arready, rvalid;
  logic measEn, sealEn, alarmLed, alarmRelay, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [3:0] wstrb = 4'hF, extClass = 4'b0001;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ackLen = 8'h0A;
  logic [11:0] actTemp = 12'h000, setTemp = 12'h064, actOut;
  logic [11:0] bandLow = 12'h000, bandHigh = 12'hFFF;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  sas_pkg::sas_err_t extErr = '0;
  int failures, check_count, cyc, tr, nf, run, mx;
  sas_supervisor #(.RESTART_CYC(RST), .BLINK_HALF(4)) u_sas_supervisor (
    .clk(clk), .rstn(rstn), .startIn(startIn), .resetIn(resetIn), .supplyLow(supplyLow),
    .termLost(termLost), .mainsTick(mainsTick), .overSet(overSet), .powerLow(powerLow),
    .actTemp(actTemp), .setTemp(setTemp), .bandLow(bandLow), .bandHigh(bandHigh),
    .extErrValid(extErrValid), .extErr(extErr), .extClass(extClass), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .measEn(measEn), .sealEn(sealEn), .alarmLed(alarmLed),
    .alarmRelay(alarmRelay), .actOut(actOut), .irq(irq));
  sas_machine_ctl u_sas_machine_ctl (.clk(clk), .runReq(runReq), .ackReq(ackReq),
    .ackLen(ackLen), .startIn(startIn), .resetIn(resetIn));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      final_report();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdreg(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    rdreg(a);
    check(nm, rd & m, e);
  endtask
  task automatic start(input logic s);
    runReq <= s;
    wt(60);
  endtask
  task automatic raise(input logic [3:0] c, input logic [11:0] k, input logic [3:0] l);
    @(posedge clk);
    extErr <= '{code: k, level: l};
    extClass <= c;
    extErrValid <= 1'b1;
    @(posedge clk);
    extErrValid <= 1'b0;
    wt(8);
  endtask
  task automatic ack(input logic expRelay);
    @(posedge clk);
    ackReq <= 1'b1;
    @(posedge clk);
    ackReq <= 1'b0;
    wt(9);
    check("relay held", alarmRelay, expRelay);
    wt(8);
    check("led cleared", alarmLed, 1'b0);
    check("meas held", measEn, 1'b0);
    wt(RST + 10);
    check("meas resumed", measEn, 1'b1);
  endtask
  task automatic blink();
    logic last;
    tr = 0;
    nf = 0;
    last = alarmLed;
    repeat (64) begin
      @(posedge clk);
      if (alarmLed !== last) tr++;
      last = alarmLed;
      if (actOut === 12'hFFF) nf++;
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    wt(8);
    rstn <= 1'b1;
    wt(4);
    rchk("pause", `SAS_OFS_PAUSE, 32'h0000_00FF, 32'h0000_000A);
    rdreg(8'h20);
    check("unmapped resp", rsp, 2'b10);
    check("unmapped data", rd, 32'h0000_0000);
    actTemp <= 12'h00A;
    wr(`SAS_OFS_HEATLIM, 32'h0000_001E);
    check("wr resp", rsp, 2'b00);
    wr(8'h20, 32'h0000_0001);
    check("wr unmapped", rsp, 2'b10);
    wr(`SAS_OFS_MASK, 32'h0000_0001);
    start(1'b1);
    rchk("err off", `SAS_OFS_ERR, 32'h0000_FFF0, 32'h0000_0000);
    start(1'b0);
    wr(`SAS_OFS_CTRL, 32'h0000_0001);
    actTemp <= 12'h05F;
    start(1'b1);
    rchk("err at 95", `SAS_OFS_ERR, 32'h0000_FFF0, 32'h0000_0000);
    start(1'b0);
    actTemp <= 12'h00A;
    start(1'b1);
    rchk("err 304", `SAS_OFS_ERR, 32'h0000_FFF0, 32'h0000_1300);
    check("led 304", alarmLed, 1'b1);
    check("relay 304", alarmRelay, 1'b1);
    check("irq on", irq, 1'b1);
    wr(`SAS_OFS_MASK, 32'h0000_0000);
    wt(3);
    check("irq masked", irq, 1'b0);
    start(1'b0);
    wr(`SAS_OFS_CTRL, 32'h0000_0000);
    ack(1'b1);
    wr(`SAS_OFS_IRQ, 32'h0000_0007);
    wr(`SAS_OFS_MASK, 32'h0000_0007);
    rchk("irq clear", `SAS_OFS_IRQ, 32'h0000_0007, 32'h0000_0000);
    check("irq off", irq, 1'b0);
    raise(4'b1000, 12'h065, 4'h1);
    check("fault out", actOut, 12'h100);
    wr(`SAS_OFS_CTRL, 32'h0000_0004);
    wt(4);
    check("relay inv", alarmRelay, 1'b0);
    wr(`SAS_OFS_CTRL, 32'h0000_0000);
    ack(1'b1);
    termLost <= 1'b1;
    runReq <= 1'b1;
    wr(`SAS_OFS_CTRL, 32'h0000_0004);
    wt(4);
    check("idle inv", alarmRelay, 1'b1);
    supplyLow <= 1'b1;
    wt(10);
    check("stby meas", measEn, 1'b0);
    check("stby seal", sealEn, 1'b0);
    check("stby out", actOut, 12'h000);
    check("stby relay", alarmRelay, 1'b0);
    supplyLow <= 1'b0;
    wt(10);
    check("back meas", measEn, 1'b1);
    check("back relay", alarmRelay, 1'b1);
    check("back seal", sealEn, 1'b1);
    runReq <= 1'b0;
    wr(`SAS_OFS_CTRL, 32'h0000_0000);
    rchk("term err", `SAS_OFS_ERR, 32'h0000_FFF0, 32'h0000_0000);
    check("term relay", alarmRelay, 1'b0);
    raise(4'b0010, 12'h068, 4'h8);
    blink();
    check("cal blink", tr >= 14 && tr <= 17, 1'b1);
    check("cal alt", nf >= 26 && nf <= 38, 1'b1);
    check("cal relay", alarmRelay, 1'b0);
    runReq <= 1'b1;
    wt(8);
    blink();
    check("cal steady", tr, 0);
    check("cal fixed", nf, 0);
    check("cal level", actOut, 12'h800);
    check("cal start relay", alarmRelay, 1'b1);
    runReq <= 1'b0;
    wt(4);
    ack(1'b0);
    raise(4'b0100, 12'h06F, 4'h9);
    blink();
    check("cfg blink", tr >= 3 && tr <= 5, 1'b1);
    check("cfg alt", nf >= 26 && nf <= 38, 1'b1);
    ack(1'b0);
    bandLow <= 12'h005;
    wr(`SAS_OFS_CTRL, 32'h0000_0002);
    start(1'b1);
    actTemp <= 12'h003;
    wt(8);
    rchk("err 307", `SAS_OFS_ERR, 32'h0000_FFF0, 32'h0000_1330);
    check("led 307", alarmLed, 1'b1);
    start(1'b0);
    wr(`SAS_OFS_CTRL, 32'h0000_0000);
    actTemp <= 12'h00A;
    ack(1'b1);
    runReq <= 1'b1;
    overSet <= 1'b1;
    powerLow <= 1'b1;
    repeat (160) begin
      @(posedge clk);
      mainsTick <= (cyc % 4 == 0);
      run = measEn ? 0 : run + int'(mainsTick);
      if (run > mx) mx = run;
    end
    check("pause cap", mx <= 10, 1'b1);
    final_report();
  end
endmodule // tb_top
